// File: core/core_data_memory_pc_stack.sv
// data memory map, indirect addressing, program counter and return stack
`timescale 1ns/1ps
`default_nettype none
module core_data_memory_pc_stack #(
  parameter bit BIG_VARIANT = 1'b1
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    ce,
  input  wire core_mem_pkg::data_req_s dreq,
  input  wire core_mem_pkg::flow_req_s freq,
  input  wire logic                    bankSelectBit,
  input  wire logic                    upperBankReservedBit,
  input  wire logic                    indirectBankBit,
  input  wire logic [4:0]              pcHighLatch,
  output logic      [7:0]              rdata,
  output logic                         rvalid,
  output logic      [12:0]             pc,
  output logic      [7:0]              filePointer,
  output logic                         specialHit,
  output logic      [8:0]              dataAddr
);
  logic [7:0]  ram [128];
  logic [7:0]  next_ram [128];
  logic [7:0]  next_rdata;
  logic        next_rvalid;
  logic [12:0] next_pc;
  logic [7:0]  next_filePointer;
  logic        next_specialHit;
  logic [8:0]  next_dataAddr;
  logic [8:0]  effAddr;
  logic        viaPort;
  logic        selfRef;
  logic        ramHit;
  logic [6:0]  ramIdx;
  logic        stackPush;
  logic        stackPop;
  logic [12:0] stackTop;
  logic [12:0] pcPlus;

  assign pcPlus = pc + 13'h0001;

  always_comb begin
    viaPort = (dreq.fileAddr == core_mem_pkg::PORT_OFFSET);
    if (viaPort) begin
      effAddr = {indirectBankBit, filePointer};
    end else begin
      effAddr = {1'b0, bankSelectBit, dreq.fileAddr};
    end
    selfRef = viaPort && (effAddr[6:0] == core_mem_pkg::PORT_OFFSET);
  end

  always_comb begin
    ramHit = 1'b0;
    ramIdx = effAddr[6:0];
    if (effAddr[8] == 1'b0 && effAddr[6:0] > core_mem_pkg::SPECIAL_TOP) begin
      if (!effAddr[7]) begin
        ramHit = BIG_VARIANT ? 1'b1 : (effAddr[6:0] >= core_mem_pkg::SMALL_B0_LO);
      end else if (effAddr[6:0] >= core_mem_pkg::MIRROR_LO) begin
        ramHit = BIG_VARIANT ? 1'b1 : 1'b1;
      end else if (BIG_VARIANT && effAddr[6:0] <= core_mem_pkg::BIG_B1_HI) begin
        ramHit = 1'b1;
        ramIdx = effAddr[6:0] - core_mem_pkg::BIG_B0_LO;  // a0h-bfh -> 00h-1fh
      end
    end
  end

  // register file storage, direct or indirect
  genvar g;
  generate
    for (g = 0; g < 128; g++) begin : gRam
      always_comb begin
        next_ram[g] = ram[g];
        if (dreq.wr && ramHit && !selfRef && ramIdx == 7'(g)) begin
          next_ram[g] = dreq.wdata;
        end
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ram[g] <= core_mem_pkg::ZERO_BYTE;
        end else if (ce) begin
          ram[g] <= next_ram[g];
        end
      end
    end
  endgenerate

  // read data and pointer register
  always_comb begin
    next_rvalid      = dreq.rd;
    next_rdata       = core_mem_pkg::ZERO_BYTE;
    next_filePointer = filePointer;
    next_specialHit  = dreq.rd | dreq.wr ? (effAddr[6:0] <= core_mem_pkg::SPECIAL_TOP) : 1'b0;
    next_dataAddr    = effAddr;
    if (dreq.rd) begin
      if (selfRef) begin
        next_rdata = core_mem_pkg::ZERO_BYTE;
      end else if (effAddr[6:0] == core_mem_pkg::PCLOW_OFFSET) begin
        next_rdata = pc[7:0];
      end else if (effAddr[6:0] == core_mem_pkg::PTR_OFFSET) begin
        next_rdata = filePointer;
      end else if (ramHit) begin
        next_rdata = ram[ramIdx];
      end else begin
        next_rdata = core_mem_pkg::ZERO_BYTE;
      end
    end
    if (dreq.wr && !selfRef && effAddr[6:0] == core_mem_pkg::PTR_OFFSET) begin
      next_filePointer = dreq.wdata;
    end
  end

  assign stackPush = freq.call | freq.irq;
  assign stackPop  = freq.ret & ~stackPush;

  // program counter next value
  always_comb begin
    next_pc = pc;
    if (freq.irq) begin
      next_pc = freq.vector;
    end else if (freq.ret) begin
      next_pc = stackTop;
    end else if (dreq.wr && !selfRef && effAddr[6:0] == core_mem_pkg::PCLOW_OFFSET) begin
      // low byte write with latch 4:0
      next_pc = {pcHighLatch, dreq.wdata};
    end else if (freq.jump) begin
      next_pc = {pcHighLatch[4:3], freq.target};
    end else if (freq.step) begin
      next_pc = pcPlus;
    end
  end

  // upper bits have no data path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc          <= core_mem_pkg::PC_RESET;
      rdata       <= core_mem_pkg::ZERO_BYTE;
      rvalid      <= 1'b0;
      filePointer <= core_mem_pkg::ZERO_BYTE;
      specialHit  <= 1'b0;
      dataAddr    <= '0;
    end else if (ce) begin
      pc          <= next_pc;
      rdata       <= next_rdata;
      rvalid      <= next_rvalid;
      filePointer <= next_filePointer;
      specialHit  <= next_specialHit;
      dataAddr    <= next_dataAddr;
    end
  end

  // latch is an input, never written by stack
  return_stack #(
    .DEPTH (core_mem_pkg::STACK_DEPTH),
    .PW    (core_mem_pkg::SPTR_W),
    .AW    (core_mem_pkg::PC_W)
  ) uStack (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .push     (stackPush),
    .pop      (stackPop),
    .pushData (freq.irq ? pc : pcPlus),
    .top      (stackTop)
  );

  // assertions
  pc_reset_a: assert property (@(posedge clk) $rose(rstn) |-> pc == 13'h0000)
    else $error("pc not zero after reset");
  pc_write_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && dreq.wr && !viaPort && !freq.irq && !freq.ret
    && dreq.fileAddr == 7'h02 |=> pc == {$past(pcHighLatch), $past(dreq.wdata)})
    else $error("low byte write did not load pc");
  jump_load_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && freq.jump && !freq.irq && !freq.ret && !dreq.wr
    |=> pc == {$past(pcHighLatch[4:3]), $past(freq.target)})
    else $error("jump target wrong");
  call_ret_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && freq.call && freq.jump && !freq.irq && !dreq.wr ##1
    ce && freq.ret && !freq.call && !freq.irq |=> pc == $past(pc, 2) + 13'h0001)
    else $error("return did not restore pc");
  unimpl_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && dreq.rd && !viaPort && bankSelectBit
    && dreq.fileAddr >= 7'h40 && dreq.fileAddr < 7'h70 |=> rdata == 8'h00)
    else $error("unimplemented read not zero");
  self_ref_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && dreq.rd && viaPort && filePointer == 8'h00 |=> rdata == 8'h00 && rvalid)
    else $error("self reference read not zero");
  mirror_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && dreq.wr && !viaPort && bankSelectBit && dreq.fileAddr == 7'h70 ##1
    ce && dreq.rd && !dreq.wr && !viaPort && !bankSelectBit && dreq.fileAddr == 7'h70
    |=> rdata == $past(dreq.wdata, 2))
    else $error("mirror window mismatch");
  ind_addr_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && dreq.rd && viaPort |=> dataAddr == {$past(indirectBankBit), $past(filePointer)})
    else $error("indirect address wrong");
  // interrupt vectoring loads the vector
  irq_load_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && freq.irq |=> pc == $past(freq.vector))
    else $error("interrupt vector not loaded");
  // interrupt then return restores interrupted pc
  irq_ret_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && freq.irq ##1 ce && freq.ret && !freq.call && !freq.irq
    |=> pc == $past(pc, 2))
    else $error("return after interrupt wrong");
  // pointer register takes direct writes
  ptr_write_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && dreq.wr && !viaPort && dreq.fileAddr == core_mem_pkg::PTR_OFFSET
    |=> filePointer == $past(dreq.wdata))
    else $error("pointer write lost");
  // direct address is bank bit over field
  direct_addr_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !viaPort |=> dataAddr == {1'b0, $past(bankSelectBit), $past(dreq.fileAddr)})
    else $error("direct address wrong");
  // plain step increments pc
  step_inc_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && freq.step && !freq.jump && !freq.irq && !freq.ret && !dreq.wr
    |=> pc == $past(pc) + 13'h0001)
    else $error("pc step wrong");
  // no read, no valid pulse
  rvalid_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !dreq.rd |=> !rvalid && rdata == core_mem_pkg::ZERO_BYTE)
    else $error("read valid without read");
  // main scenarios reached
  call_c: cover property (@(posedge clk) disable iff (!rstn) ce && freq.call);
  irq_c: cover property (@(posedge clk) disable iff (!rstn) ce && freq.irq);
  ret_c: cover property (@(posedge clk) disable iff (!rstn) ce && freq.ret);
  ind_c: cover property (@(posedge clk) disable iff (!rstn) ce && dreq.wr && viaPort);
endmodule
`default_nettype wire

// File: shared/core_mem_pkg.sv
// shared constants and carrier types for the data memory and program counter core
package core_mem_pkg;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 13;
  localparam int DADDR_W     = 9;
  localparam int STACK_DEPTH = 8;
  localparam int SPTR_W      = 3;
  localparam int LATCH_W     = 5;
  localparam int TARGET_W    = 11;
  localparam int FILE_W      = 7;
  // bank layout
  localparam logic [6:0] SPECIAL_TOP   = 7'h1f;   // first 32 of each bank
  localparam logic [6:0] BIG_B0_LO     = 7'h20;
  localparam logic [6:0] SMALL_B0_LO   = 7'h40;
  localparam logic [6:0] BIG_B1_HI     = 7'h3f;   // a0h-bfh within bank 1
  localparam logic [6:0] MIRROR_LO     = 7'h70;   // f0h-ffh -> 70h-7fh
  localparam logic [6:0] PORT_OFFSET   = 7'h00;   // indirect data port
  localparam logic [6:0] PCLOW_OFFSET  = 7'h02;   // program counter low byte
  localparam logic [6:0] PTR_OFFSET    = 7'h04;   // file select pointer
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam logic [12:0] PC_RESET     = 13'h0000;
  localparam logic [6:0] RAM_DEPTH_BIG = 7'h7f;

  // access request from the execution core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] fileAddr;
    logic [7:0] wdata;
  } data_req_s;

  // program flow request from the execution core
  typedef struct packed {
    logic        step;      // ordinary increment
    logic        jump;      // call or goto
    logic        call;      // call: push return address
    logic        irq;       // interrupt vectoring: push and load vector
    logic        ret;       // any return kind
    logic [10:0] target;
    logic [12:0] vector;
  } flow_req_s;
endpackage

// File: core/return_stack.sv
// eight entry circular return address stack
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
  parameter int DEPTH = 8,
  parameter int PW    = 3,
  parameter int AW    = 13
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic [AW-1:0] pushData,
  output logic      [AW-1:0] top
);
  logic [AW-1:0] entry [DEPTH];
  logic [AW-1:0] next_entry [DEPTH];
  logic [PW-1:0] ptr;
  logic [PW-1:0] next_ptr;

  always_comb begin
    next_ptr = ptr;
    if (push) begin
      next_ptr = ptr + 1'b1;
    end else if (pop) begin
      next_ptr = ptr - 1'b1;
    end
  end

  // per entry write on push at pointer
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gEntry
      always_comb begin
        next_entry[g] = entry[g];
        if (push && ptr == PW'(g)) begin
          next_entry[g] = pushData;
        end
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          entry[g] <= '0;
        end else if (ce) begin
          entry[g] <= next_entry[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr <= '0;
    end else if (ce) begin
      ptr <= next_ptr;
    end
  end

  assign top = entry[ptr - 1'b1];
endmodule
`default_nettype wire

// File: tb/exec_core_model.sv
// execution core model issuing data accesses and flow commands
`timescale 1ns/1ps
`default_nettype none
module exec_core_model (
  input  wire logic                    clk,
  output logic                         ce,
  output core_mem_pkg::data_req_s      dreq,
  output core_mem_pkg::flow_req_s      freq,
  output logic                         bankSelectBit,
  output logic                         upperBankReservedBit,
  output logic                         indirectBankBit,
  output logic [4:0]                   pcHighLatch
);
  // idle values from time zero
  initial begin
    ce = 1'b1;
    dreq = '0;
    freq = '0;
    bankSelectBit = 1'b0;
    upperBankReservedBit = 1'b0;
    indirectBankBit = 1'b0;
    pcHighLatch = 5'h00;
  end
  // one access, taken at a single edge
  task automatic acc(input logic wr, input logic b, input logic [6:0] a, input logic [7:0] w);
    @(negedge clk);
    bankSelectBit = b;
    dreq = {~wr, wr, a, w};
    @(negedge clk);
    dreq = '0;
  endtask
  // flow command: step jump call irq ret
  task automatic flow(input logic [4:0] c, input logic [10:0] t, input logic [12:0] v,
                      input logic [4:0] l);
    @(negedge clk);
    pcHighLatch = l;
    freq = {c, t, v};
    @(negedge clk);
    freq = '0;
  endtask
endmodule
`default_nettype wire

// File: tb/core_data_memory_pc_stack_tb.sv
// self-checking testbench for the data memory and pc core
`timescale 1ns/1ps
`default_nettype none
module core_data_memory_pc_stack_tb;
  localparam logic [4:0] STEP = 5'h10;
  localparam logic [4:0] JUMP = 5'h08;
  localparam logic [4:0] CALL = 5'h0c;
  localparam logic [4:0] IRQ  = 5'h02;
  localparam logic [4:0] RET  = 5'h01;
  logic                    clk = 1'b0;
  logic                    rstn = 1'b0;
  logic                    ce;
  core_mem_pkg::data_req_s dreq;
  core_mem_pkg::flow_req_s freq;
  logic                    bankSel;
  logic                    upperBank;
  logic                    indBank;
  logic [4:0]              latch;
  logic [7:0]              rdata;
  logic                    rvalid;
  logic [12:0]             pc;
  logic [7:0]              filePointer;
  logic                    specialHit;
  logic [8:0]              dataAddr;
  int                      failures = 0;
  int                      total_checks = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  exec_core_model cpu (.clk(clk), .ce(ce), .dreq(dreq), .freq(freq), .bankSelectBit(bankSel),
    .upperBankReservedBit(upperBank), .indirectBankBit(indBank), .pcHighLatch(latch));
  core_data_memory_pc_stack #(.BIG_VARIANT(1'b1)) dut (.clk(clk), .rstn(rstn), .ce(ce),
    .dreq(dreq), .freq(freq), .bankSelectBit(bankSel), .upperBankReservedBit(upperBank),
    .indirectBankBit(indBank), .pcHighLatch(latch), .rdata(rdata), .rvalid(rvalid), .pc(pc),
    .filePointer(filePointer), .specialHit(specialHit), .dataAddr(dataAddr));
  // compare and count
  task automatic chk(input string n, input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // read and judge data plus valid pulse
  task automatic rd(input logic b, input logic [6:0] a, input logic [7:0] e);
    cpu.acc(1'b0, b, a, 8'h00);
    chk("rvalid", {12'h000, rvalid}, 13'h0001);
    chk("rdata", {5'h00, rdata}, {5'h00, e});
  endtask
  // pc after reset
  task automatic t_reset;
    chk("pc", pc, 13'h0000);
  endtask
  // banks, mirror and unimplemented space
  task automatic t_banks;
    cpu.acc(1'b1, 1'b0, 7'h20, 8'h11);
    cpu.acc(1'b1, 1'b1, 7'h20, 8'h22);
    rd(1'b0, 7'h20, 8'h11);
    rd(1'b1, 7'h20, 8'h22);
    chk("dataAddr", {4'h0, dataAddr}, 13'h00a0);
    chk("specialHit", {12'h000, specialHit}, 13'h0000);
    cpu.acc(1'b1, 1'b0, 7'h75, 8'h5a);
    rd(1'b1, 7'h75, 8'h5a);
    cpu.acc(1'b1, 1'b1, 7'h45, 8'h77);
    rd(1'b1, 7'h45, 8'h00);
  endtask
  // pointer, data port and self reference
  task automatic t_indirect;
    cpu.acc(1'b1, 1'b0, 7'h04, 8'h40);
    chk("filePointer", {5'h00, filePointer}, 13'h0040);
    cpu.acc(1'b1, 1'b1, 7'h00, 8'h9c);
    rd(1'b0, 7'h40, 8'h9c);
    rd(1'b1, 7'h00, 8'h9c);
    chk("dataAddr", {4'h0, dataAddr}, 13'h0040);
    rd(1'b0, 7'h04, 8'h40);
    chk("specialHit", {12'h000, specialHit}, 13'h0001);
    cpu.acc(1'b1, 1'b0, 7'h04, 8'h00);
    cpu.acc(1'b1, 1'b0, 7'h00, 8'hff);
    rd(1'b0, 7'h00, 8'h00);
  endtask
  // jump, step and low byte write
  task automatic t_pc;
    cpu.flow(JUMP, 11'h123, 13'h0000, 5'h18);
    chk("pc", pc, 13'h1923);
    cpu.flow(STEP, 11'h000, 13'h0000, 5'h18);
    chk("pc", pc, 13'h1924);
    cpu.flow(5'h00, 11'h000, 13'h0000, 5'h15);
    cpu.acc(1'b1, 1'b0, 7'h02, 8'h3c);
    chk("pc", pc, 13'h153c);
  endtask
  // nine calls wrap, eight returns, interrupt push
  task automatic t_stack;
    cpu.flow(JUMP, 11'h100, 13'h0000, 5'h00);
    for (int i = 0; i < 9; i++) begin
      cpu.flow(CALL, 11'h200 + 11'(i), 13'h0000, 5'h00);
      chk("pc", pc, 13'h0200 + 13'(i));
    end
    for (int k = 0; k < 8; k++) begin
      cpu.flow(RET, 11'h000, 13'h0000, 5'h00);
      chk("pc", pc, 13'h0208 - 13'(k));
    end
    cpu.flow(JUMP, 11'h050, 13'h0000, 5'h00);
    cpu.flow(IRQ, 11'h000, 13'h0004, 5'h00);
    chk("pc", pc, 13'h0004);
    cpu.flow(RET, 11'h000, 13'h0000, 5'h00);
    chk("pc", pc, 13'h0050);
  endtask
  // verdict and end of run
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    failures++;
    results();
  end
  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_banks();
    t_indirect();
    t_pc();
    t_stack();
    results();
  end
endmodule
`default_nettype wire
